/* File: hw/thermal_supply_supervisor.sv */
// Behaviour
// - Temperature is supervised in all modes except Sleep and Off.
// - Overheat enters Overtemp, holds reset low, drops rails and CAN.
// - Below release threshold, Overtemp goes through Reset into Standby.
// - Crossing the warning threshold sets warning status and event.
// - Battery below power-off threshold forces Off from any mode.
// - 5 V parts keep the core rail on in Off until battery below 2 V.
// - Battery above power-on level, after start-up delay: Off to Reset.
// - Leaving Off after power-up sets the supply-up event.
// - Pass transistor follows load current; split bit picks thresholds.
// - Core rail below selected trip threshold causes a system reset.
// - 3.3 V parts use a fixed 90 percent trip threshold.
// - Each battery start-up loads trip select from its boot default.
// - Core below 90 percent latches a warning event when enabled.
// - A status bit shows whether core is below 90 percent.
// - Auxiliary rail is on only as its configuration field says.
// - CAN wake-up is detected even with the auxiliary rail off.
// - Power-on loads auxiliary rail configuration from its boot default.
// - Off-board rail is on only as its configuration field says.
// - Power-on loads off-board rail configuration from its boot default.
// - Rail status field reports auxiliary or off-board rail state.
// - Trip codes 00,01,10,11 mean 90,80,70,60 percent.
// - Rail codes: off, Normal, plus Standby and Reset, plus Sleep.
// - Boot default 0 loads rail code 00, 1 loads 11.
// - Rail status codes: ok, under, over, disabled.
`timescale 1ns/100ps
`default_nettype none

module thermal_supply_supervisor
    import tss_pkg::*;
#(
    parameter bit FIVE_VOLT = 1'b1,
    parameter bit EXT_RAIL = 1'b0,
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int RESET_CYCLES = RESET_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Classic Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog comparator outputs, asynchronous.
    input wire logic temp_shutdown_i,
    input wire logic temp_release_i,
    input wire logic temp_warn_i,
    input wire logic bat_poff_i,
    input wire logic bat_pon_i,
    input wire logic bat_below_2v_i,
    input wire logic [3:0] core_below_i,
    input wire logic rail_under_i,
    input wire logic rail_over_i,
    input wire logic pass_act_hi_i,
    input wire logic pass_deact_hi_i,
    input wire logic pass_act_lo_i,
    input wire logic pass_deact_lo_i,
    input wire logic can_wake_i,
    // Supply and reset controls.
    output logic reset_out_n_o,
    output logic core_rail_en_o,
    output logic aux_rail_en_o,
    output logic offboard_rail_en_o,
    output logic pass_en_o,
    output logic can_en_o,
    output logic [2:0] mode_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << CNT_W)) begin : g_chk_s
        $error("STARTUP_CYCLES out of range");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << CNT_W)) begin : g_chk_r
        $error("RESET_CYCLES out of range");
    end

    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYCLES - 1);

    typedef struct packed {
        mode_t mode;
        logic [CNT_W-1:0] cnt;
        logic [1:0] trip;
        logic [1:0] rail;
        logic split;
        logic warn_en;
        logic [1:0] boot_trip;
        logic boot_rail;
        logic ev_core;
        logic ev_ot;
        logic ev_up;
        logic ot_prev;
        logic core_prev;
        logic pass_on;
        logic retain;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------------
    // Comparator synchronisation
    // ------------------------------------------------------------------
    logic [CMP_W-1:0] cmp_raw;
    logic [CMP_W-1:0] cmp;

    assign cmp_raw = {can_wake_i, pass_deact_lo_i, pass_act_lo_i,
                      pass_deact_hi_i, pass_act_hi_i, rail_over_i,
                      rail_under_i, core_below_i, bat_below_2v_i,
                      bat_pon_i, bat_poff_i, temp_warn_i,
                      temp_release_i, temp_shutdown_i};

    sync2 #(
        .WIDTH(CMP_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(cmp_raw),
        .sync_o(cmp)
    );

    // ------------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------------
    logic temp_active;
    logic core_on;
    logic rail_on;
    logic core_uv;
    logic ot_status;
    logic [1:0] trip_eff;
    logic [1:0] rail_status;
    logic [31:0] rd_mux;
    logic [7:0] ofs;
    logic wr;
    logic mode_wr;
    logic ev_clr_wr;
    logic [2:0] ev_clr;

    assign ofs = adr_i[7:0];
    assign temp_active = s_q.mode != MODE_SLEEP &&
                         s_q.mode != MODE_OFF;
    assign trip_eff = FIVE_VOLT ? s_q.trip : 2'h0;
    assign core_uv = cmp[CMP_CORE_LSB + int'(trip_eff)];
    assign ot_status = temp_active && cmp[CMP_T_WARN];
    assign core_on = s_q.mode == MODE_RESET || s_q.mode == MODE_STANDBY ||
                     s_q.mode == MODE_NORMAL ||
                     (s_q.mode == MODE_OFF && s_q.retain);

    always_comb begin
        case (s_q.rail)
            RAIL_CFG_OFF: rail_on = 1'b0;
            RAIL_CFG_NORMAL: rail_on = s_q.mode == MODE_NORMAL;
            RAIL_CFG_AWAKE: rail_on = s_q.mode == MODE_NORMAL ||
                                      s_q.mode == MODE_STANDBY ||
                                      s_q.mode == MODE_RESET;
            RAIL_CFG_ALWAYS: rail_on = s_q.mode == MODE_NORMAL ||
                                       s_q.mode == MODE_STANDBY ||
                                       s_q.mode == MODE_RESET ||
                                       s_q.mode == MODE_SLEEP;
            default: rail_on = 1'b0;
        endcase
    end

    always_comb begin
        if (!rail_on) begin
            rail_status = RAIL_ST_DISABLED;
        end else if (cmp[CMP_AUX_OVER]) begin
            rail_status = RAIL_ST_OVER;
        end else if (cmp[CMP_AUX_UNDER]) begin
            rail_status = RAIL_ST_UNDER;
        end else begin
            rail_status = RAIL_ST_OK;
        end
    end

    // ------------------------------------------------------------------
    // Register read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0;
        case (ofs)
            REG_CTRL_OFS: begin
                rd_mux[CTRL_TRIP_LSB +: 2] = trip_eff;
                rd_mux[CTRL_RAIL_LSB +: 2] = s_q.rail;
                rd_mux[CTRL_SPLIT_BIT] = s_q.split;
            end
            REG_STATUS_OFS: begin
                rd_mux[STAT_CORE_LOW_BIT] = cmp[CMP_CORE_LSB];
                rd_mux[STAT_RAIL_LSB +: 2] = rail_status;
                rd_mux[STAT_OT_WARN_BIT] = ot_status;
                rd_mux[STAT_MODE_LSB +: 3] = s_q.mode;
            end
            REG_EVT_EN_OFS: rd_mux[EN_CORE_WARN_BIT] = s_q.warn_en;
            REG_EVENT_OFS: begin
                rd_mux[EV_CORE_LOW_BIT] = s_q.ev_core;
                rd_mux[EV_OT_WARN_BIT] = s_q.ev_ot;
                rd_mux[EV_SUPPLY_UP_BIT] = s_q.ev_up;
            end
            REG_BOOT_OFS: begin
                rd_mux[BOOT_TRIP_LSB +: 2] = s_q.boot_trip;
                rd_mux[BOOT_RAIL_BIT] = s_q.boot_rail;
            end
            REG_MODE_OFS: rd_mux[2:0] = s_q.mode;
            default: rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus write decode
    // ------------------------------------------------------------------
    // A write takes effect on the edge at which the master sees ack.
    assign wr = cyc_i && stb_i && we_i && s_q.ack && sel_i[0];
    assign mode_wr = wr && ofs == REG_MODE_OFS;
    assign ev_clr_wr = wr && ofs == REG_EVENT_OFS;
    assign ev_clr = ev_clr_wr ? dat_i[2:0] : 3'h0;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = cyc_i && stb_i && !s_q.ack;
        if (cyc_i && stb_i && !s_q.ack) begin
            s_d.rdata = rd_mux;
        end

        if (wr && ofs == REG_CTRL_OFS) begin
            s_d.trip = dat_i[CTRL_TRIP_LSB +: 2];
            s_d.rail = dat_i[CTRL_RAIL_LSB +: 2];
            s_d.split = dat_i[CTRL_SPLIT_BIT];
        end
        if (wr && ofs == REG_EVT_EN_OFS) begin
            s_d.warn_en = dat_i[EN_CORE_WARN_BIT];
        end
        if (wr && ofs == REG_BOOT_OFS) begin
            s_d.boot_trip = dat_i[BOOT_TRIP_LSB +: 2];
            s_d.boot_rail = dat_i[BOOT_RAIL_BIT];
        end

        // Events: a set in the same cycle as a clear wins.
        s_d.ot_prev = ot_status;
        s_d.core_prev = cmp[CMP_CORE_LSB];
        s_d.ev_ot = (s_q.ev_ot && !ev_clr[EV_OT_WARN_BIT]) ||
                    (ot_status && !s_q.ot_prev);
        s_d.ev_core = (s_q.ev_core && !ev_clr[EV_CORE_LOW_BIT]) ||
                      (s_q.warn_en && cmp[CMP_CORE_LSB] &&
                       !s_q.core_prev);
        s_d.ev_up = s_q.ev_up && !ev_clr[EV_SUPPLY_UP_BIT];

        // Pass transistor hysteresis on the chosen threshold pair.
        if (!core_on || s_q.mode == MODE_OFF) begin
            s_d.pass_on = 1'b0;
        end else if (s_q.split) begin
            s_d.pass_on = s_q.pass_on ? !cmp[CMP_DEACT_LO] : cmp[CMP_ACT_LO];
        end else begin
            s_d.pass_on = s_q.pass_on ? !cmp[CMP_DEACT_HI] : cmp[CMP_ACT_HI];
        end

        if (cmp[CMP_B_2V] || !FIVE_VOLT) begin
            s_d.retain = 1'b0;
        end

        if (cmp[CMP_B_POFF] && s_q.mode != MODE_OFF) begin
            s_d.mode = MODE_OFF;
            s_d.cnt = '0;
            s_d.retain = FIVE_VOLT && !cmp[CMP_B_2V];
        end else begin
            case (s_q.mode)
                MODE_OFF: begin
                    if (cmp[CMP_B_PON] && !cmp[CMP_B_POFF]) begin
                        if (s_q.cnt >= START_LAST) begin
                            s_d.mode = MODE_RESET;
                            s_d.cnt = '0;
                            s_d.retain = 1'b0;
                            s_d.ev_up = 1'b1;
                            s_d.trip = s_q.boot_trip;
                            s_d.rail = s_q.boot_rail ? RAIL_CFG_ALWAYS :
                                       RAIL_CFG_OFF;
                        end else begin
                            s_d.cnt = s_q.cnt + 1'b1;
                        end
                    end else begin
                        s_d.cnt = '0;
                    end
                end
                MODE_OVERTEMP: begin
                    if (cmp[CMP_T_REL]) begin
                        s_d.mode = MODE_RESET;
                        s_d.cnt = '0;
                    end
                end
                MODE_RESET: begin
                    if (cmp[CMP_T_SHUT]) begin
                        s_d.mode = MODE_OVERTEMP;
                    end else if (core_uv) begin
                        s_d.cnt = '0;
                    end else if (s_q.cnt >= RESET_LAST) begin
                        s_d.mode = MODE_STANDBY;
                        s_d.cnt = '0;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                MODE_STANDBY, MODE_NORMAL: begin
                    if (cmp[CMP_T_SHUT]) begin
                        s_d.mode = MODE_OVERTEMP;
                    end else if (core_uv) begin
                        s_d.mode = MODE_RESET;
                        s_d.cnt = '0;
                    end else if (mode_wr && (dat_i[2:0] == MODE_STANDBY ||
                                 dat_i[2:0] == MODE_NORMAL ||
                                 dat_i[2:0] == MODE_SLEEP)) begin
                        s_d.mode = mode_t'(dat_i[2:0]);
                    end
                end
                MODE_SLEEP: begin
                    // Wake detection does not depend on the rail state.
                    if (cmp[CMP_WAKE]) begin
                        s_d.mode = MODE_RESET;
                        s_d.cnt = '0;
                    end
                end
                default: begin
                    s_d.mode = MODE_OFF;
                    s_d.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.mode <= MODE_OFF;
            s_q.boot_trip <= BOOT_TRIP_RST;
            s_q.boot_rail <= BOOT_RAIL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ack_o = s_q.ack;
    assign dat_o = s_q.rdata;
    assign mode_o = s_q.mode;
    assign reset_out_n_o = !(s_q.mode == MODE_OFF ||
                             s_q.mode == MODE_RESET ||
                             s_q.mode == MODE_OVERTEMP);
    assign core_rail_en_o = core_on;
    assign aux_rail_en_o = !EXT_RAIL && rail_on;
    assign offboard_rail_en_o = EXT_RAIL && rail_on;
    assign pass_en_o = s_q.pass_on;
    assign can_en_o = s_q.mode == MODE_NORMAL && (EXT_RAIL || rail_on);

endmodule

`default_nettype wire

/* File: hw/tss_pkg.sv */
package tss_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_RESET_PULSE_US = 1000;
    localparam int T_STARTUP_US = 100;
    localparam int RESET_PULSE_CYC = T_RESET_PULSE_US * CLK_MHZ;
    localparam int STARTUP_CYC = T_STARTUP_US * CLK_MHZ;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_EVT_EN_OFS = 8'h08;
    localparam logic [7:0] REG_EVENT_OFS = 8'h0c;
    localparam logic [7:0] REG_BOOT_OFS = 8'h10;
    localparam logic [7:0] REG_MODE_OFS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TRIP_LSB = 0;
    localparam int CTRL_RAIL_LSB = 2;
    localparam int CTRL_SPLIT_BIT = 6;
    localparam int STAT_CORE_LOW_BIT = 0;
    localparam int STAT_RAIL_LSB = 1;
    localparam int STAT_OT_WARN_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int EN_CORE_WARN_BIT = 0;
    localparam int EV_CORE_LOW_BIT = 0;
    localparam int EV_OT_WARN_BIT = 1;
    localparam int EV_SUPPLY_UP_BIT = 2;
    localparam int BOOT_TRIP_LSB = 0;
    localparam int BOOT_RAIL_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values of the non-volatile boot defaults, and rail configuration codes
    // ------------------------------------------------------------------
    localparam logic [1:0] BOOT_TRIP_RST = 2'h0;
    localparam logic BOOT_RAIL_RST = 1'b0;
    localparam logic [1:0] RAIL_CFG_OFF = 2'h0;
    localparam logic [1:0] RAIL_CFG_NORMAL = 2'h1;
    localparam logic [1:0] RAIL_CFG_AWAKE = 2'h2;
    localparam logic [1:0] RAIL_CFG_ALWAYS = 2'h3;

    // Rail status codes.
    localparam logic [1:0] RAIL_ST_OK = 2'h0;
    localparam logic [1:0] RAIL_ST_UNDER = 2'h1;
    localparam logic [1:0] RAIL_ST_OVER = 2'h2;
    localparam logic [1:0] RAIL_ST_DISABLED = 2'h3;

    // ------------------------------------------------------------------
    // Comparator input positions
    // ------------------------------------------------------------------
    localparam int CMP_W = 17;
    localparam int CMP_T_SHUT = 0;
    localparam int CMP_T_REL = 1;
    localparam int CMP_T_WARN = 2;
    localparam int CMP_B_POFF = 3;
    localparam int CMP_B_PON = 4;
    localparam int CMP_B_2V = 5;
    localparam int CMP_CORE_LSB = 6;
    localparam int CMP_AUX_UNDER = 10;
    localparam int CMP_AUX_OVER = 11;
    localparam int CMP_ACT_HI = 12;
    localparam int CMP_DEACT_HI = 13;
    localparam int CMP_ACT_LO = 14;
    localparam int CMP_DEACT_LO = 15;
    localparam int CMP_WAKE = 16;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_RESET = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_NORMAL = 3'b011,
        MODE_SLEEP = 3'b100,
        MODE_OVERTEMP = 3'b101
    } mode_t;

endpackage

/* File: hw/sync2.sv */
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d.meta = async_i;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stable;

endmodule

`default_nettype wire

/* File: verif/tss_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module tss_sva
    import tss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bat_poff_i,
    input wire logic bat_below_2v_i,
    input wire logic reset_out_n_o,
    input wire logic core_rail_en_o,
    input wire logic aux_rail_en_o,
    input wire logic pass_en_o,
    input wire logic can_en_o,
    input wire logic [2:0] mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_rst;
        reset_out_n_o == (mode_o inside {MODE_STANDBY, MODE_NORMAL,
            MODE_SLEEP});
    endproperty
    a_rst: assert property (p_rst) else $error("reset output wrong");
    property p_ot_off;
        mode_o == MODE_OVERTEMP && $past(mode_o) == MODE_OVERTEMP |->
            !(core_rail_en_o | aux_rail_en_o | pass_en_o | can_en_o);
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("rail on in overtemp");
    property p_ot_exit;
        $past(mode_o) == MODE_OVERTEMP && mode_o != MODE_OVERTEMP |->
            mode_o inside {MODE_RESET, MODE_OFF};
    endproperty
    a_ot_exit: assert property (p_ot_exit) else $error("bad overtemp exit");
    property p_poff;
        bat_poff_i [*3] |-> ##[0:2] mode_o == MODE_OFF;
    endproperty
    a_poff: assert property (p_poff) else $error("no off mode");
    property p_off_exit;
        $past(mode_o) == MODE_OFF && mode_o != MODE_OFF |->
            mode_o == MODE_RESET;
    endproperty
    a_off_exit: assert property (p_off_exit) else $error("bad off exit");
    property p_sleep;
        $past(mode_o) == MODE_SLEEP && mode_o != MODE_SLEEP |->
            mode_o inside {MODE_RESET, MODE_OFF};
    endproperty
    a_sleep: assert property (p_sleep) else $error("bad sleep exit");
    property p_ret;
        (mode_o == MODE_OFF && bat_below_2v_i) [*4] |-> !core_rail_en_o;
    endproperty
    a_ret: assert property (p_ret) else $error("core kept below 2 V");
    property p_aux;
        mode_o inside {MODE_OFF, MODE_OVERTEMP} |-> !aux_rail_en_o;
    endproperty
    a_aux: assert property (p_aux) else $error("aux rail on");
    property p_can;
        can_en_o |-> mode_o == MODE_NORMAL;
    endproperty
    a_can: assert property (p_can) else $error("can on outside normal");
    c_ot: cover property (mode_o == MODE_OVERTEMP);
    c_wake: cover property (mode_o == MODE_SLEEP ##1 mode_o == MODE_RESET);
    c_pass: cover property (pass_en_o);
endmodule
bind thermal_supply_supervisor tss_sva u_tss_sva (.*);
`default_nettype wire

/* File: verif/mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mcu_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_in_n_i,
    input wire logic supply_i,
    output logic running_o,
    output logic [7:0] boots_o
);
    // Counts each start of the processor with power and reset released.
    logic run_q;
    assign running_o = supply_i & reset_in_n_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
            boots_o <= 8'h00;
        end else begin
            run_q <= running_o;
            if (running_o && !run_q) begin
                boots_o <= boots_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("wrong value at %0t: got %0h want %0h", $time, a, b); \
    end \
end
module tb
    import tss_pkg::*;
;
    logic clk_i = 1'b0, rst_n_i = 1'b0, req = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, q, dat_o;
    logic temp_shutdown_i = 1'b0, temp_release_i = 1'b1, temp_warn_i = 1'b0;
    logic bat_poff_i = 1'b0, bat_pon_i = 1'b0, bat_below_2v_i = 1'b0;
    logic [3:0] core_below_i = 4'h0;
    logic rail_under_i = 1'b0, rail_over_i = 1'b0, can_wake_i = 1'b0;
    logic pass_act_hi_i = 1'b0, pass_deact_hi_i = 1'b0;
    logic pass_act_lo_i = 1'b0, pass_deact_lo_i = 1'b0;
    logic ack_o, reset_out_n_o, core_rail_en_o, aux_rail_en_o;
    logic offboard_rail_en_o, pass_en_o, can_en_o, running;
    logic [2:0] mode_o;
    logic [7:0] boots;
    int failures = 0, total_checks = 0, cycles = 0;
    thermal_supply_supervisor #(.STARTUP_CYCLES(4), .RESET_CYCLES(8))
        u_thermal_supply_supervisor (.cyc_i(req), .stb_i(req),
        .sel_i(4'hf), .*);
    mcu_model u_mcu_model (.clk_i, .rst_n_i, .reset_in_n_i(reset_out_n_o),
        .supply_i(core_rail_en_o), .running_o(running), .boots_o(boots));
    // ------------------------------------------------------------------
    // Clock, timeout and bus tasks
    // ------------------------------------------------------------------
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        req <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CK(q, e)
    endtask
    task automatic wm(mode_t m);
        for (int i = 0; i < 60 && mode_o !== m; i++) @(posedge clk_i);
        `CK(mode_o, m)
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_boot();
        rc(REG_BOOT_OFS, 32'h0);
        wr(REG_BOOT_OFS, 32'hb);
        bat_pon_i <= 1'b1;
        wm(MODE_RESET);
        rc(REG_EVENT_OFS, 32'h4);
        rc(REG_CTRL_OFS, 32'hf);
        wm(MODE_STANDBY);
        wr(REG_EVENT_OFS, 32'h7);
        rc(8'h20, 32'h0);
        $display("boot test done");
    endtask
    task automatic t_rail();
        for (int i = 0; i < 3; i++) begin
            rail_under_i <= (i == 1);
            rail_over_i <= (i == 2);
            wt(4);
            bus(1'b0, REG_STATUS_OFS, 32'h0);
            `CK(q[STAT_RAIL_LSB+:2], 2'(i))
        end
        rail_over_i <= 1'b0;
        `CK(aux_rail_en_o, 1'b1)
        wr(REG_CTRL_OFS, 32'h7);
        wt(1);
        `CK(aux_rail_en_o, 1'b0)
        wr(REG_MODE_OFS, 32'h3);
        wt(1);
        `CK(can_en_o, 1'b1)
        wr(REG_CTRL_OFS, 32'h3);
        rc(REG_STATUS_OFS, {MODE_NORMAL, 4'h6});
        `CK({aux_rail_en_o, can_en_o, offboard_rail_en_o}, 3'h0)
        wr(REG_MODE_OFS, 32'h2);
        wr(REG_CTRL_OFS, 32'hf);
        $display("rail test done");
    endtask
    task automatic t_core();
        core_below_i <= 4'h1;
        wt(4);
        rc(REG_STATUS_OFS, {MODE_STANDBY, 4'h1});
        rc(REG_EVENT_OFS, 32'h0);
        core_below_i <= 4'h0;
        wr(REG_EVT_EN_OFS, 32'h1);
        core_below_i <= 4'h1;
        wt(4);
        rc(REG_EVENT_OFS, 32'h1);
        core_below_i <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL_OFS, 32'hc | 32'(k));
            core_below_i <= 4'((1 << k) - 1);
            wt(6);
            `CK(mode_o, MODE_STANDBY)
            core_below_i <= 4'((2 << k) - 1);
            wm(MODE_RESET);
            core_below_i <= 4'h0;
            wm(MODE_STANDBY);
        end
        wr(REG_EVENT_OFS, 32'h7);
        $display("core test done");
    endtask
    task automatic t_heat();
        temp_warn_i <= 1'b1;
        wt(4);
        rc(REG_STATUS_OFS, {MODE_STANDBY, 4'h8});
        rc(REG_EVENT_OFS, 32'h2);
        temp_warn_i <= 1'b0;
        temp_release_i <= 1'b0;
        temp_shutdown_i <= 1'b1;
        wm(MODE_OVERTEMP);
        wt(1);
        `CK({reset_out_n_o, core_rail_en_o, running}, 3'b000)
        temp_shutdown_i <= 1'b0;
        temp_release_i <= 1'b1;
        wm(MODE_RESET);
        wm(MODE_STANDBY);
        wr(REG_EVENT_OFS, 32'h7);
        $display("heat test done");
    endtask
    task automatic t_sleep();
        wr(REG_CTRL_OFS, 32'h3);
        wr(REG_MODE_OFS, 32'h4);
        wm(MODE_SLEEP);
        temp_release_i <= 1'b0;
        temp_shutdown_i <= 1'b1;
        temp_warn_i <= 1'b1;
        wt(8);
        `CK(mode_o, MODE_SLEEP)
        rc(REG_EVENT_OFS, 32'h0);
        {temp_shutdown_i, temp_warn_i, temp_release_i} <= 3'b001;
        wt(3);
        can_wake_i <= 1'b1;
        wm(MODE_RESET);
        can_wake_i <= 1'b0;
        wm(MODE_STANDBY);
        wr(REG_CTRL_OFS, 32'hf);
        $display("sleep test done");
    endtask
    task automatic t_pass();
        pass_act_hi_i <= 1'b1;
        wt(4);
        `CK(pass_en_o, 1'b1)
        {pass_act_hi_i, pass_deact_hi_i} <= 2'b01;
        wt(4);
        `CK(pass_en_o, 1'b0)
        wr(REG_CTRL_OFS, 32'h4f);
        {pass_act_hi_i, pass_deact_hi_i} <= 2'b10;
        wt(4);
        `CK(pass_en_o, 1'b0)
        pass_act_lo_i <= 1'b1;
        wt(4);
        `CK(pass_en_o, 1'b1)
        {pass_act_hi_i, pass_act_lo_i, pass_deact_lo_i} <= 3'b001;
        wt(4);
        `CK(pass_en_o, 1'b0)
        pass_deact_lo_i <= 1'b0;
        $display("pass test done");
    endtask
    task automatic t_off();
        logic [7:0] b0;
        b0 = boots;
        {bat_pon_i, bat_poff_i} <= 2'b01;
        wm(MODE_OFF);
        wt(2);
        `CK(core_rail_en_o, 1'b1)
        bat_below_2v_i <= 1'b1;
        wt(5);
        `CK(core_rail_en_o, 1'b0)
        wr(REG_BOOT_OFS, 32'h1);
        {bat_below_2v_i, bat_poff_i, bat_pon_i} <= 3'b001;
        wm(MODE_RESET);
        rc(REG_CTRL_OFS, 32'h41);
        wm(MODE_STANDBY);
        rc(REG_EVENT_OFS, 32'h4);
        `CK(boots, b0 + 8'h01)
        $display("off test done");
    endtask
    initial begin
        wt(5);
        rst_n_i <= 1'b1;
        t_boot();
        t_rail();
        t_core();
        t_heat();
        t_sleep();
        t_pass();
        t_off();
        complete_run();
    end
endmodule
`default_nettype wire
